// ### hw/sapf_host_framer.sv
`timescale 1ns/1ps
module sapf_host_framer
  import sapf_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,  // Payload buffer words
  parameter int RX_MAX     = 64   // Largest frame data kept
) (
  input  wire logic         ref_clk,         // Clock, 125 MHz
  input  wire logic         rst,             // Async reset, high
  input  wire logic         ce,              // Clock enable
  input  wire logic [1:0]   interfaceSelect, // Modem mode setting
  input  wire logic         reqValid,        // Request offered
  output      logic         reqReady,        // Request taken
  input  wire sapf_txreq_t  req,             // Request fields
  input  wire logic         payValid,        // Payload byte offered
  output      logic         payReady,        // Buffer not full
  input  wire logic [7:0]   payByte,         // Payload byte
  output      logic         linkTxValid,     // Byte to modem
  input  wire logic         linkTxReady,     // Serialiser accepts
  output      logic [7:0]   linkTxByte,      // Byte to modem
  input  wire logic         linkRxValid,     // Byte from modem
  input  wire logic [7:0]   linkRxByte,      // Received byte
  output      logic         rxInfoValid,     // Good frame decoded
  output      sapf_rxinfo_t rxInfo,          // Decoded header
  output      logic         rxDataValid,     // Payload byte pulse
  output      logic [7:0]   rxDataByte,      // Payload byte
  output      logic         rxDataLast,      // Last payload byte
  output      logic         txBusy           // Frame being sent
);
  // ----------------------------------------------------------------
  // Types and signals
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h0,
    TX_DELIM = 4'h1,
    TX_LENH  = 4'h2,
    TX_LENL  = 4'h3,
    TX_TYPE  = 4'h4,
    TX_FID   = 4'h5,
    TX_DSTH  = 4'h6,
    TX_DSTL  = 4'h7,
    TX_OPT   = 4'h8,
    TX_PAY   = 4'h9,
    TX_CSUM  = 4'hA
  } sapf_txst_t;

  typedef enum logic [2:0] {
    RX_HUNT = 3'h0,
    RX_LENH = 3'h1,
    RX_LENL = 3'h2,
    RX_DATA = 3'h3,
    RX_CSUM = 3'h4,
    RX_PLAY = 3'h5
  } sapf_rxst_t;

  sapf_txst_t  txSt_q;          // Transmit state
  sapf_txreq_t req_q;           // Latched request
  logic [15:0] payLeft_q;       // Payload bytes left
  logic [7:0]  txSum_q;         // Transmit sum
  logic [15:0] frameLen;        // Length field value
  logic        framed;          // Framed mode
  logic        escMode;         // Escaped mode
  logic        encValid;        // Byte offered to escaper
  logic        encReady;        // Escaper takes byte
  logic [7:0]  encByte;         // Byte offered to escaper
  logic        encRaw;          // Byte bypasses escaping
  logic        encAccept;       // Byte handed over
  logic        fifoValid;       // Payload available
  logic        fifoPop;         // Take payload byte
  logic [7:0]  fifoByte;        // Head payload byte

  sapf_rxst_t  rxSt_q;          // Receive state
  logic        rxEsc_q;         // Escape marker seen
  logic [15:0] rxLen_q;         // Received length field
  logic [15:0] rxIdx_q;         // Data byte index
  logic [7:0]  rxSum_q;         // Running receive sum
  logic [15:0] rxPtr_q;         // Playback index
  logic [7:0]  rxMem [RX_MAX];  // Frame data store
  logic [7:0]  rxB;             // Unescaped byte
  logic        rxTake;          // Byte enters the parser
  logic        rxRestart;       // Raw delimiter seen
  logic [15:0] payStart;        // First payload index
  sapf_rxinfo_t info_q;         // Decoded header
  logic        infoValid_q;     // Decoded header pulse
  logic        dValid_q;        // Payload byte pulse
  logic [7:0]  dByte_q;         // Payload byte register
  logic        dLast_q;         // Last byte flag

  assign framed   = (interfaceSelect != MODE_TRANSP);
  assign escMode  = (interfaceSelect == MODE_ESC);
  assign frameLen = req_q.len + TXREQ_HDR;
  assign reqReady = framed && (txSt_q == TX_IDLE);
  assign txBusy   = (txSt_q != TX_IDLE);
  assign encAccept = encValid && encReady;

  // ----------------------------------------------------------------
  // Payload buffer and escaper
  // ----------------------------------------------------------------
  sapf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .inValid  (payValid),
    .inReady  (payReady),
    .inData   (payByte),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoByte)
  );

  sapf_esc_tx u_esc (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .escEn    (escMode),
    .inValid  (encValid),
    .inReady  (encReady),
    .inByte   (encByte),
    .inRaw    (encRaw),
    .outValid (linkTxValid),
    .outReady (linkTxReady),
    .outByte  (linkTxByte)
  );

  // ----------------------------------------------------------------
  // Transmit byte selection
  // ----------------------------------------------------------------
  // Unescaped byte for the frame position
  always_comb
  begin
    encValid = 1'b1;
    encRaw   = 1'b0;
    encByte  = 8'h00;
    fifoPop  = 1'b0;
    unique case (txSt_q)
      TX_IDLE:
      begin
        // Pass-through drain
        encValid = !framed && fifoValid;
        encRaw   = 1'b1;
        encByte  = fifoByte;
        fifoPop  = !framed && encReady;
      end
      TX_DELIM:
      begin
        encRaw  = 1'b1;
        encByte = DELIM_BYTE;
      end
      TX_LENH: encByte = frameLen[15:8];
      TX_LENL: encByte = frameLen[7:0];
      TX_TYPE: encByte = TYPE_TXREQ;
      TX_FID:  encByte = req_q.frameId;
      TX_DSTH: encByte = req_q.dest[15:8];
      TX_DSTL: encByte = req_q.dest[7:0];
      TX_OPT:  encByte = req_q.options;
      TX_PAY:
      begin
        // Stalls when empty
        encValid = fifoValid;
        encByte  = fifoByte;
        fifoPop  = encReady;
      end
      TX_CSUM: encByte = CSUM_GOOD - txSum_q;
      default:
      begin
        encValid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Transmit sequencing
  // ----------------------------------------------------------------
  // One state per accepted byte, except TX_PAY, which holds for every payload byte
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      txSt_q    <= TX_IDLE;
      req_q     <= '0;
      payLeft_q <= 16'h0000;
    end
    else if (ce)
    begin
      if (txSt_q == TX_IDLE)
      begin
        if (reqValid && reqReady)
        begin
          req_q     <= req;
          payLeft_q <= req.len;
          txSt_q    <= TX_DELIM;
        end
      end
      else if (encAccept)
      begin
        unique case (txSt_q)
          TX_DELIM: txSt_q <= TX_LENH;
          TX_LENH:  txSt_q <= TX_LENL;
          TX_LENL:  txSt_q <= TX_TYPE;
          TX_TYPE:  txSt_q <= TX_FID;
          TX_FID:   txSt_q <= TX_DSTH;
          TX_DSTH:  txSt_q <= TX_DSTL;
          TX_DSTL:  txSt_q <= TX_OPT;
          TX_OPT:   txSt_q <= (payLeft_q == 16'h0000) ? TX_CSUM : TX_PAY;
          TX_PAY:
          begin
            payLeft_q <= payLeft_q - 16'h0001;
            if (payLeft_q == 16'h0001)
              txSt_q <= TX_CSUM;
          end
          default:  txSt_q <= TX_IDLE;
        endcase
      end
    end
  end

  // Sums frame data before escaping
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      txSum_q <= 8'h00;
    else if (ce)
    begin
      if (txSt_q == TX_DELIM)
        txSum_q <= 8'h00;
      else if (encAccept && (txSt_q >= TX_TYPE) && (txSt_q <= TX_PAY))
        txSum_q <= txSum_q + encByte;
    end
  end

  // ----------------------------------------------------------------
  // Receive parsing
  // ----------------------------------------------------------------
  assign rxRestart = escMode && (linkRxByte == DELIM_BYTE);
  assign rxB       = rxEsc_q ? (linkRxByte ^ ESC_XOR) : linkRxByte;
  assign rxTake    = ce && framed && linkRxValid && !rxRestart
                     && !(escMode && !rxEsc_q && (linkRxByte == ESC_BYTE))
                     && (rxSt_q != RX_PLAY);

  // Payload start by frame type
  always_comb
  begin
    unique case (rxMem[0])
      TYPE_RXPKT:  payStart = RXPKT_HDR;
      TYPE_TXSTAT: payStart = TXSTAT_HDR;
      TYPE_MSTAT:  payStart = MSTAT_HDR;
      default:     payStart = OTHER_HDR;
    endcase
  end

  // Frame data store
  always_ff @(posedge ref_clk)
  begin
    if (rxTake && (rxSt_q == RX_DATA))
      rxMem[rxIdx_q[$clog2(RX_MAX)-1:0]] <= rxB;
  end

  // Delimiter hunt, length, checksum and decode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rxSt_q      <= RX_HUNT;
      rxEsc_q     <= 1'b0;
      rxLen_q     <= 16'h0000;
      rxIdx_q     <= 16'h0000;
      rxSum_q     <= 8'h00;
      rxPtr_q     <= 16'h0000;
      info_q      <= '0;
      infoValid_q <= 1'b0;
    end
    else if (ce)
    begin
      infoValid_q <= 1'b0;
      if (rxSt_q == RX_PLAY)
      begin
        // Payload playback
        rxPtr_q <= rxPtr_q + 16'h0001;
        if (rxPtr_q + 16'h0001 >= rxLen_q)
          rxSt_q <= RX_HUNT;
      end
      else if (framed && linkRxValid && rxRestart)
      begin
        // Raw delimiter restarts
        rxSt_q  <= RX_LENH;
        rxEsc_q <= 1'b0;
      end
      else if (framed && linkRxValid && escMode && !rxEsc_q && (linkRxByte == ESC_BYTE))
        rxEsc_q <= 1'b1;
      else if (rxTake)
      begin
        rxEsc_q <= 1'b0;
        unique case (rxSt_q)
          RX_HUNT:
            if (linkRxByte == DELIM_BYTE)
              rxSt_q <= RX_LENH;
          RX_LENH:
          begin
            rxLen_q[15:8] <= rxB;
            rxSt_q        <= RX_LENL;
          end
          RX_LENL:
          begin
            rxLen_q[7:0] <= rxB;
            rxIdx_q      <= 16'h0000;
            rxSum_q      <= 8'h00;
            // Drop empty or oversize
            if (({rxLen_q[15:8], rxB} == 16'h0000) || ({rxLen_q[15:8], rxB} > 16'(RX_MAX)))
              rxSt_q <= RX_HUNT;
            else
              rxSt_q <= RX_DATA;
          end
          RX_DATA:
          begin
            rxSum_q <= rxSum_q + rxB;
            rxIdx_q <= rxIdx_q + 16'h0001;
            if (rxIdx_q + 16'h0001 == rxLen_q)
              rxSt_q <= RX_CSUM;
          end
          RX_CSUM:
          begin
            if (8'(rxSum_q + rxB) == CSUM_GOOD)
            begin
              // Decode header fields by type
              info_q.typeId  <= rxMem[0];
              info_q.srcAddr <= {rxMem[1], rxMem[2]};
              info_q.frameId <= rxMem[1];
              info_q.status  <= (rxMem[0] == TYPE_TXSTAT) ? rxMem[2] : rxMem[1];
              info_q.rssi    <= rxMem[3];
              info_q.options <= rxMem[4];
              info_q.noAck   <= (rxMem[0] == TYPE_TXSTAT) && (rxMem[2] == STAT_NOACK);
              info_q.purged  <= (rxMem[0] == TYPE_TXSTAT) && (rxMem[2] == STAT_PURGED);
              info_q.payLen  <= (rxLen_q > payStart) ? rxLen_q - payStart : 16'h0000;
              infoValid_q    <= 1'b1;
              rxPtr_q        <= payStart;
              rxSt_q         <= (rxLen_q > payStart) ? RX_PLAY : RX_HUNT;
            end
            else
              rxSt_q <= RX_HUNT;
          end
          default: rxSt_q <= RX_HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive data output
  // ----------------------------------------------------------------
  // Playback or pass-through
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dValid_q <= 1'b0;
      dByte_q  <= 8'h00;
      dLast_q  <= 1'b0;
    end
    else if (ce)
    begin
      dValid_q <= 1'b0;
      dLast_q  <= 1'b0;
      if (!framed && linkRxValid)
      begin
        dValid_q <= 1'b1;
        dByte_q  <= linkRxByte;
      end
      else if (rxSt_q == RX_PLAY)
      begin
        dValid_q <= 1'b1;
        dByte_q  <= rxMem[rxPtr_q[$clog2(RX_MAX)-1:0]];
        dLast_q  <= (rxPtr_q + 16'h0001 >= rxLen_q);
      end
    end
  end

  assign rxInfoValid = infoValid_q;
  assign rxInfo      = info_q;
  assign rxDataValid = dValid_q;
  assign rxDataByte  = dByte_q;
  assign rxDataLast  = dLast_q;
endmodule // sapf_host_framer

// ### hw/sapf_pkg.sv
package sapf_pkg;

  // ----------------------------------------------------------------
  // Framing bytes and modes
  // ----------------------------------------------------------------
  localparam logic [7:0] DELIM_BYTE  = 8'h7E;  // Start delimiter
  localparam logic [7:0] ESC_BYTE    = 8'h7D;  // Escape marker
  localparam logic [7:0] XON_BYTE    = 8'h11;  // Flow-control on
  localparam logic [7:0] XOFF_BYTE   = 8'h13;  // Flow-control off
  localparam logic [7:0] ESC_XOR     = 8'h20;  // Escape flip mask
  localparam logic [7:0] CSUM_GOOD   = 8'hFF;  // Checksum constant

  localparam logic [1:0] MODE_TRANSP = 2'h0;   // Pass-through
  localparam logic [1:0] MODE_API    = 2'h1;   // Framed
  localparam logic [1:0] MODE_ESC    = 2'h2;   // Framed, escaped

  // ----------------------------------------------------------------
  // Frame type identifiers and layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  TYPE_TXREQ  = 8'h01;  // Transmit request
  localparam logic [7:0]  TYPE_RXPKT  = 8'h81;  // Receive packet
  localparam logic [7:0]  TYPE_TXSTAT = 8'h89;  // Transmit status
  localparam logic [7:0]  TYPE_MSTAT  = 8'h8A;  // Modem status
  localparam logic [15:0] TXREQ_HDR   = 16'h0005; // Type,id,dst(2),opt
  localparam logic [15:0] RXPKT_HDR   = 16'h0005; // Type,src(2),rssi,opt
  localparam logic [15:0] TXSTAT_HDR  = 16'h0003; // Type,id,status
  localparam logic [15:0] MSTAT_HDR   = 16'h0002; // Type,status
  localparam logic [15:0] OTHER_HDR   = 16'h0001; // Type only
  localparam logic [7:0]  STAT_NOACK  = 8'h01;  // Retries expired
  localparam logic [7:0]  STAT_PURGED = 8'h03;  // Poll never came

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  frameId;   // Frame identifier
    logic [15:0] dest;      // Destination address
    logic [7:0]  options;   // Option byte
    logic [15:0] len;       // Payload byte count
  } sapf_txreq_t;

  typedef struct packed {
    logic [7:0]  typeId;    // Frame type
    logic [15:0] srcAddr;   // Source address
    logic [7:0]  frameId;   // Frame id
    logic [7:0]  status;    // Status byte
    logic [7:0]  rssi;      // Signal byte
    logic [7:0]  options;   // Option byte
    logic        noAck;     // Retries expired
    logic        purged;    // Purged
    logic [15:0] payLen;    // Payload count
  } sapf_rxinfo_t;

  // Bytes that must be escaped
  function automatic logic isSpecial(input logic [7:0] b);
    return (b == DELIM_BYTE) || (b == ESC_BYTE) || (b == XON_BYTE) || (b == XOFF_BYTE);
  endfunction

endpackage

// ### hw/sapf_fifo.sv
`timescale 1ns/1ps
module sapf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,  // Clock
  input  wire logic             rst,      // Async reset
  input  wire logic             ce,       // Clock enable
  input  wire logic             inValid,  // Write request
  output      logic             inReady,  // Not full
  input  wire logic [WIDTH-1:0] inData,   // Write data
  output      logic             outValid, // Not empty
  input  wire logic             outReady, // Read request
  output      logic [WIDTH-1:0] outData   // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0]    wrPtr_q;      // Write index
  logic [AW-1:0]    rdPtr_q;      // Read index
  logic [AW:0]      count_q;      // Words held
  logic             push;         // Accepted write
  logic             pop;          // Accepted read

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage write
  always_ff @(posedge ref_clk)
  begin
    if (ce && push)
      mem[wrPtr_q] <= inData;
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else if (ce)
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule // sapf_fifo

// ### hw/sapf_esc_tx.sv
`timescale 1ns/1ps
module sapf_esc_tx
  import sapf_pkg::*;
(
  input  wire logic       ref_clk,  // Clock
  input  wire logic       rst,      // Async reset
  input  wire logic       ce,       // Clock enable
  input  wire logic       escEn,    // Escaping active
  input  wire logic       inValid,  // Byte offered
  output      logic       inReady,  // Byte taken
  input  wire logic [7:0] inByte,   // Unescaped byte
  input  wire logic       inRaw,    // Never escape (delimiter)
  output      logic       outValid, // Link byte valid
  input  wire logic       outReady, // Link accepts
  output      logic [7:0] outByte   // Link byte
);
  logic       pend_q;   // Escape half pending
  logic [7:0] pendB_q;  // Flipped byte to send
  logic       needEsc;  // Current byte needs escape

  assign needEsc  = escEn && !inRaw && isSpecial(inByte);
  assign inReady  = !pend_q && outReady;
  assign outValid = pend_q || inValid;
  assign outByte  = pend_q ? pendB_q : (needEsc ? ESC_BYTE : inByte);

  // Escape pair sequencing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pend_q  <= 1'b0;
      pendB_q <= 8'h00;
    end
    else if (ce)
    begin
      if (pend_q && outReady)
        pend_q <= 1'b0;
      else if (inValid && inReady && needEsc)
      begin
        pend_q  <= 1'b1;
        pendB_q <= inByte ^ ESC_XOR;
      end
    end
  end
endmodule // sapf_esc_tx

// ### test/sapf_chk.sv
`timescale 1ns/1ps
module sapf_chk
  import sapf_pkg::*;
(
  input wire logic       ref_clk,         // Clock
  input wire logic       rst,             // Async reset
  input wire logic       ce,              // Clock enable
  input wire logic [1:0] interfaceSelect, // Mode
  input wire logic       reqValid,        // Request offered
  input wire logic       reqReady,        // Request taken
  input wire logic       linkTxValid,     // Link byte valid
  input wire logic       linkTxReady,     // Link accepts
  input wire logic [7:0] linkTxByte,      // Link byte
  input wire logic       linkRxValid,     // Byte from modem
  input wire logic [7:0] linkRxByte,      // Its value
  input wire logic       rxInfoValid,     // Good frame pulse
  input wire logic       rxDataValid,     // Payload pulse
  input wire logic [7:0] rxDataByte,      // Payload byte
  input wire logic       txBusy           // Frame in progress
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  req_delim_a: assert property (ce && reqValid && reqReady |=> linkTxValid && linkTxByte == DELIM_BYTE)
    else $error("No delimiter");
  transp_refuse_a: assert property (interfaceSelect == MODE_TRANSP |-> !reqReady)
    else $error("Request in transparent");
  busy_refuse_a: assert property (txBusy |-> !reqReady)
    else $error("Request while busy");
  hold_byte_a: assert property (ce && linkTxValid && !linkTxReady |=> linkTxValid && $stable(linkTxByte))
    else $error("Byte not held");
  esc_delim_a: assert property (interfaceSelect == MODE_ESC && linkTxValid && linkTxByte == DELIM_BYTE
    |-> !$past(txBusy) || $past(linkTxValid && linkTxByte == DELIM_BYTE)) else $error("Unescaped delimiter");
  esc_pair_a: assert property (ce && interfaceSelect == MODE_ESC && txBusy && linkTxValid && linkTxReady
    && linkTxByte == ESC_BYTE |=> linkTxValid && (linkTxByte inside {8'h5E, 8'h5D, 8'h31, 8'h33}))
    else $error("Bad escape pair");
  rx_transp_a: assert property (interfaceSelect == MODE_TRANSP && ce && linkRxValid
    |=> rxDataValid && rxDataByte == $past(linkRxByte)) else $error("Byte not passed");
  info_after_a: assert property (rxInfoValid |-> $past(ce && linkRxValid))
    else $error("Report without byte");
  busy_end_a: assert property ($fell(txBusy) |-> $past(linkTxValid && linkTxReady))
    else $error("Busy end without byte");
  cover property (ce && reqValid && reqReady);
  cover property (rxInfoValid);
  cover property (interfaceSelect == MODE_ESC && linkTxValid && linkTxByte == ESC_BYTE);
endmodule // sapf_chk

// ### test/sapf_modem.sv
`timescale 1ns/1ps
module sapf_modem
  import sapf_pkg::*;
(
  input  wire logic       ref_clk, // Clock
  input  wire logic       slow,    // Stall every other cycle
  input  wire logic [1:0] mode,    // Mode copy
  input  wire logic       txValid, // Byte from controller
  output      logic       txReady, // Byte accepted
  input  wire logic [7:0] txByte,  // Byte value
  output      logic       rxValid, // Byte to controller
  output      logic [7:0] rxByte   // Byte value
);
  logic [7:0] got[$];       // Last good frame
  logic [7:0] raw[$];       // Every byte taken
  logic [7:0] code = 8'h00; // Reply status
  int         badCnt = 0;   // Bad checksums
  initial rxValid = 1'b0;
  initial rxByte = 8'h00;
  initial txReady = 1'b1;
  // Stalls when slow; handshake read at the settled falling edge
  always @(posedge ref_clk) txReady <= slow ? ~txReady : 1'b1;
  always @(negedge ref_clk) if (txValid && txReady) raw.push_back(txByte);
  task automatic take(output logic [7:0] b);
    do @(negedge ref_clk); while (!(txValid && txReady));
    b = txByte;
  endtask
  task automatic pull(output logic [7:0] b);
    take(b);
    if (mode == MODE_ESC && b == ESC_BYTE)
    begin
      take(b);
      b = b ^ ESC_XOR;
    end
  endtask
  // Idle line shows inverse
  task automatic put(input logic [7:0] b);
    @(posedge ref_clk); rxValid <= 1'b1; rxByte <= b;
    @(posedge ref_clk); rxValid <= 1'b0; rxByte <= ~b;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic putEsc(input logic [7:0] b);
    if (mode == MODE_ESC && (b inside {DELIM_BYTE, ESC_BYTE, XON_BYTE, XOFF_BYTE}))
    begin
      put(ESC_BYTE);
      put(b ^ ESC_XOR);
    end
    else put(b);
  endtask
  task automatic send(input logic [7:0] d[$], input logic [7:0] flip);
    logic [7:0] s;
    s = 8'h00;
    put(DELIM_BYTE);
    putEsc(8'(d.size() >> 8));
    putEsc(8'(d.size()));
    foreach (d[i]) begin putEsc(d[i]); s += d[i]; end
    putEsc((CSUM_GOOD - s) ^ flip);
  endtask
  // Parses frames, answers requests
  initial forever
  begin
    logic [7:0] b, h, l, s;
    logic [7:0] d[$], q[$];
    take(b);
    if (b == DELIM_BYTE && mode != MODE_TRANSP)
    begin
      pull(h); pull(l); s = 8'h00; d = {};
      repeat ({h, l}) begin pull(b); d.push_back(b); s += b; end
      pull(b);
      if (s + b != CSUM_GOOD) badCnt++;
      else begin got = d; q = {TYPE_TXSTAT, d[1], code}; if (d[0] == TYPE_TXREQ) send(q, 8'h00); end
    end
  end
endmodule // sapf_modem

// ### test/tb_sapf_host_framer.sv
`timescale 1ns/1ps
module tb_sapf_host_framer;
  import sapf_pkg::*;
  logic         ref_clk = 0, rst = 1, ce = 1, reqValid = 0, payValid = 0, slow = 0; // Drives
  logic [1:0]   mode    = MODE_API; // Mode setting
  sapf_txreq_t  req     = '0;       // Request fields
  logic [7:0]   payByte = 8'h00;    // Payload byte
  logic         reqReady, payReady, txV, txR, rxV, infoV, dV, dL, txBusy; // Design handshakes
  logic [7:0]   txB, rxB, dB;       // Link and data bytes
  sapf_rxinfo_t info, infoQ[$];     // Decoded headers
  logic [7:0]   dataQ[$];           // Payload seen
  int           mismatches = 0, compares = 0, lastN = 0;
  initial forever #4 ref_clk = ~ref_clk;
  sapf_host_framer u_dut(.ref_clk(ref_clk), .rst(rst), .ce(ce), .interfaceSelect(mode), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .payValid(payValid), .payReady(payReady), .payByte(payByte),
    .linkTxValid(txV), .linkTxReady(txR), .linkTxByte(txB), .linkRxValid(rxV), .linkRxByte(rxB),
    .rxInfoValid(infoV), .rxInfo(info), .rxDataValid(dV), .rxDataByte(dB), .rxDataLast(dL), .txBusy(txBusy));
  sapf_modem u_modem(.ref_clk(ref_clk), .slow(slow), .mode(mode), .txValid(txV), .txReady(txR), .txByte(txB),
    .rxValid(rxV), .rxByte(rxB));
  // Collect output once settled
  always @(negedge ref_clk)
  begin
    if (infoV) infoQ.push_back(info);
    if (dV) dataQ.push_back(dB);
    if (dV && dL) lastN = dataQ.size();
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got) begin mismatches++; $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end
  endtask
  // Wait for n-th frame
  task automatic waitInfo(input int n);
    for (int t = 0; t < 5000 && infoQ.size() < n; t++) @(negedge ref_clk);
    if (infoQ.size() < n) begin chk("frameWait", 1, 0); end_of_test(); end
  endtask
  // Request, then its status
  task automatic s_txreq(input logic [1:0] m, input logic [7:0] p[$], input logic [7:0] c, input logic sl);
    int n0;
    logic [7:0] e[$];
    mode = m; slow = sl; u_modem.code = c; n0 = infoQ.size();
    foreach (p[i]) begin payValid = 1; payByte = p[i]; @(negedge ref_clk); end
    payValid = 0;
    chk("payReady", p.size() < 16, payReady);
    req = '{8'h5A, 16'h7E11, 8'h13, 16'(p.size())}; reqValid = 1;
    chk("reqReady", 1, reqReady);
    @(negedge ref_clk) reqValid = 0;
    waitInfo(n0 + 1);
    e = {TYPE_TXREQ, 8'h5A, 8'h7E, 8'h11, 8'h13, p};
    chk("frameLen", e.size(), u_modem.got.size());
    foreach (e[i]) chk("frameByte", e[i], u_modem.got[i]);
    chk("badFrames", 0, u_modem.badCnt);
    chk("statType", TYPE_TXSTAT, infoQ[n0].typeId);
    chk("statId", 8'h5A, infoQ[n0].frameId);
    chk("statFlags", {c == STAT_NOACK, c == STAT_PURGED}, {infoQ[n0].noAck, infoQ[n0].purged});
  endtask
  // Noise, good, bad, status
  task automatic s_rx(input logic [1:0] m);
    int n0, d0;
    logic [7:0] f[$];
    mode = m; n0 = infoQ.size(); d0 = dataQ.size();
    u_modem.put(8'h11);
    f = {TYPE_RXPKT, 8'h12, 8'h7D, 8'h40, 8'h00, 8'h7E, 8'h13};
    u_modem.send(f, 8'h00);
    waitInfo(n0 + 1);
    repeat (4) @(negedge ref_clk);
    chk("rxType", TYPE_RXPKT, infoQ[n0].typeId);
    chk("rxSrc", 16'h127D, infoQ[n0].srcAddr);
    chk("rxLen", 2, infoQ[n0].payLen);
    chk("rxData", 16'h7E13, {dataQ[d0], dataQ[d0 + 1]});
    chk("rxLast", d0 + 2, lastN);
    u_modem.send(f, 8'h01);
    repeat (20) @(negedge ref_clk);
    chk("dropped", {16'(n0 + 1), 16'(d0 + 2)}, {16'(infoQ.size()), 16'(dataQ.size())});
    f = {TYPE_MSTAT, 8'h02, 8'h99};
    u_modem.send(f, 8'h00);
    waitInfo(n0 + 2);
    chk("modemStat", {TYPE_MSTAT, 8'h02}, {infoQ[n0 + 1].typeId, infoQ[n0 + 1].status});
  endtask
  // Pass-through both ways
  task automatic s_transp();
    int r0, d0, n0;
    mode = MODE_TRANSP; r0 = u_modem.raw.size(); d0 = dataQ.size(); n0 = infoQ.size();
    payValid = 1; payByte = 8'h7E; @(negedge ref_clk);
    payByte = 8'hA5; @(negedge ref_clk) payValid = 0;
    chk("reqReady", 0, reqReady);
    u_modem.put(8'h7E);
    repeat (10) @(negedge ref_clk);
    chk("rawOut", {8'(r0 + 2), 16'h7EA5}, {8'(u_modem.raw.size()), u_modem.raw[r0], u_modem.raw[r0 + 1]});
    chk("rawIn", {8'(d0 + 1), 8'(n0), 8'h7E}, {8'(dataQ.size()), 8'(infoQ.size()), dataQ[d0]});
  endtask
  initial
  begin
    logic [7:0] p[$];
    for (int i = 0; i < 16; i++) p.push_back(8'(i * 17));
    repeat (10) @(negedge ref_clk);
    rst = 0;
    @(negedge ref_clk);
    s_txreq(MODE_API, p, STAT_NOACK, 0);
    p = {8'h7E, 8'h7D, 8'h11, 8'h13};
    s_txreq(MODE_ESC, p, STAT_PURGED, 1);
    s_rx(MODE_API);
    s_rx(MODE_ESC);
    s_transp();
    end_of_test();
  end
endmodule // tb_sapf_host_framer
bind sapf_host_framer sapf_chk u_chk(.ref_clk(ref_clk), .rst(rst), .ce(ce), .interfaceSelect(interfaceSelect),
  .reqValid(reqValid), .reqReady(reqReady), .linkTxValid(linkTxValid), .linkTxReady(linkTxReady),
  .linkTxByte(linkTxByte), .linkRxValid(linkRxValid), .linkRxByte(linkRxByte), .rxInfoValid(rxInfoValid),
  .rxDataValid(rxDataValid), .rxDataByte(rxDataByte), .txBusy(txBusy));
